// ===== hw/teleprinter_serial_interface.v
// teleprinter serial interface: register file, receiver and transmitter
// Function
// (RULE1) transmit vector 244-247, receive vector 248-251
// (RULE2) receive buffer read at FFF2
// (RULE3) transmit buffer written at FFF6
// (RULE4) receive status FFF0, enable bit cleared reset
// (RULE5) receive error and done read-only, reset zero
// (RULE6) transmit status FFF4, enable bit reset zero
// (RULE7) transmit done read-only, reset to one
// (RULE8) complete received character sets receive done
// (RULE9) receive buffer read clears done and error
// (RULE10) character arriving while done set sets error
// (RULE11) software reads buffer within 100 ms
// (RULE12) enabled done or error rise sets request
// (RULE13) receive status read clears receive request
// (RULE14) transmit buffer write starts send, clears done
// (RULE15) transmit done sets after character fully sent
// (RULE16) enabled done rise sets transmit request
// (RULE17) transmit status read clears transmit request
// (RULE18) 11-unit frames at 10 characters per second
// (RULE19) receive and transmit run independently
// (RULE20) one start, eight data LSB first, two stops
// (RULE21) done flag sits in bit 7
// (RULE22) mid-unit sampling, short start pulses rejected
`timescale 1ns/1ns
`include "teleprinter_regs.vh"
module teleprinter_serial_interface #(
    parameter UNIT_CYCLES = `UNIT_CYCLES
) (
    input wire core_clk_in,
    input wire reset_in,
    input wire [15:0] addr_in,
    input wire rd_in,
    input wire wr_in,
    input wire [7:0] wdata_in,
    output reg [7:0] rdata_out,
    input wire serial_rx_in,
    output reg serial_tx_out,
    output reg rx_irq_out,
    output reg tx_irq_out,
    output reg [15:0] rx_vector_out,
    output reg [15:0] tx_vector_out
);
    localparam [3:0] RX_IDLE = 4'h1;
    localparam [3:0] RX_START = 4'h2;
    localparam [3:0] RX_DATA = 4'h4;
    localparam [3:0] RX_STOP = 4'h8;
    localparam [3:0] TX_IDLE = 4'h1;
    localparam [3:0] TX_START = 4'h2;
    localparam [3:0] TX_DATA = 4'h4;
    localparam [3:0] TX_STOP = 4'h8;
    localparam [31:0] HALF_UNIT = UNIT_CYCLES / 2;

    function [7:0] status_byte;
        input done;
        input ie;
        input err;
        begin
            status_byte = 8'h00;
            status_byte[`DONE_BIT] = done;
            status_byte[`IE_BIT] = ie;
            status_byte[`ERROR_BIT] = err;
        end
    endfunction

    // every register strobe is one address match qualified by rd or wr
    function reg_hit;
        input strobe;
        input [15:0] addr;
        input [15:0] target;
        begin
            reg_hit = strobe && (addr == target);
        end
    endfunction

    // two-stage synchroniser; only the second stage feeds logic
    reg rx_meta_reg;
    reg rx_sync_reg;
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= serial_rx_in;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    wire rd_rx_status = reg_hit(rd_in, addr_in, `RX_STATUS_ADDR);
    wire rd_rx_buffer = reg_hit(rd_in, addr_in, `RX_BUFFER_ADDR);
    wire rd_tx_status = reg_hit(rd_in, addr_in, `TX_STATUS_ADDR);
    wire wr_rx_status = reg_hit(wr_in, addr_in, `RX_STATUS_ADDR);
    wire wr_tx_status = reg_hit(wr_in, addr_in, `TX_STATUS_ADDR);
    wire wr_tx_buffer = reg_hit(wr_in, addr_in, `TX_BUFFER_ADDR);

    // receiver
    reg [3:0] rx_state_reg;
    reg [31:0] rx_count_reg;
    reg [2:0] rx_bit_reg;
    reg [7:0] rx_shift_reg;
    reg rx_word_valid_reg;
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            rx_state_reg <= RX_IDLE;
            rx_count_reg <= 32'h0000_0000;
            rx_bit_reg <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_word_valid_reg <= 1'b0;
        end else begin
            rx_word_valid_reg <= 1'b0;
            case (rx_state_reg)
                RX_IDLE: begin
                    rx_count_reg <= 32'h0000_0000;
                    if (!rx_sync_reg) begin
                        rx_state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_sync_reg) begin
                        rx_state_reg <= RX_IDLE; // see (RULE22)
                    end else if (rx_count_reg == HALF_UNIT - 1) begin
                        rx_count_reg <= 32'h0000_0000;
                        rx_bit_reg <= 3'h0;
                        rx_state_reg <= RX_DATA;
                    end else begin
                        rx_count_reg <= rx_count_reg + 32'h0000_0001;
                    end
                end
                RX_DATA: begin
                    if (rx_count_reg == UNIT_CYCLES - 1) begin
                        rx_count_reg <= 32'h0000_0000;
                        rx_shift_reg <= {rx_sync_reg, rx_shift_reg[7:1]}; // see (RULE20)
                        rx_bit_reg <= rx_bit_reg + 3'h1;
                        if (rx_bit_reg == 3'h7) begin
                            rx_state_reg <= RX_STOP;
                        end
                    end else begin
                        rx_count_reg <= rx_count_reg + 32'h0000_0001;
                    end
                end
                RX_STOP: begin
                    // mid first stop unit; second stop left to idle-hunt
                    if (rx_count_reg == UNIT_CYCLES - 1) begin
                        rx_count_reg <= 32'h0000_0000;
                        rx_word_valid_reg <= rx_sync_reg;
                        rx_state_reg <= RX_IDLE;
                    end else begin
                        rx_count_reg <= rx_count_reg + 32'h0000_0001;
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // two-entry buffer between receiver and the processor-visible buffer
    reg [7:0] fifo_data_reg [0:1];
    reg fifo_rd_ptr_reg;
    reg fifo_wr_ptr_reg;
    reg [1:0] fifo_count_reg;
    // drains every cycle without a buffer read, so it never fills in practice
    wire fifo_in_ready = (fifo_count_reg != 2'h2);
    wire fifo_out_valid = (fifo_count_reg != 2'h0);
    // drain into the buffer whenever software is not mid-read
    wire fifo_out_ready = !rd_rx_buffer;
    wire fifo_push = rx_word_valid_reg && fifo_in_ready;
    wire fifo_pop = fifo_out_valid && fifo_out_ready;
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            fifo_rd_ptr_reg <= 1'b0;
            fifo_wr_ptr_reg <= 1'b0;
            fifo_count_reg <= 2'h0;
            fifo_data_reg[0] <= 8'h00;
            fifo_data_reg[1] <= 8'h00;
        end else begin
            if (fifo_push) begin
                fifo_data_reg[fifo_wr_ptr_reg] <= rx_shift_reg;
                fifo_wr_ptr_reg <= ~fifo_wr_ptr_reg;
            end
            if (fifo_pop) begin
                fifo_rd_ptr_reg <= ~fifo_rd_ptr_reg;
            end
            fifo_count_reg <= fifo_count_reg + {1'b0, fifo_push} - {1'b0, fifo_pop};
        end
    end

    // receive registers and flags
    reg [7:0] rx_buffer_reg;
    reg rx_done_reg;
    reg rx_error_reg;
    reg rx_ie_reg;
    reg rx_req_reg;
    reg rx_done_next;
    reg rx_error_next;
    // a read and a landing word never share a cycle, so no set is lost
    always @* begin
        rx_done_next = rx_done_reg;
        rx_error_next = rx_error_reg;
        if (rd_rx_buffer) begin
            rx_done_next = 1'b0;
            rx_error_next = 1'b0;
        end
        if (fifo_pop) begin
            rx_done_next = 1'b1;
            rx_error_next = rx_error_next || rx_done_reg; // see (RULE10)
        end
    end
    wire rx_rise = (rx_done_next && !rx_done_reg) || (rx_error_next && !rx_error_reg);
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            rx_buffer_reg <= 8'h00;
            rx_done_reg <= 1'b0; // see (RULE5)
            rx_error_reg <= 1'b0;
            rx_ie_reg <= `RX_IE_RESET; // see (RULE4)
            rx_req_reg <= 1'b0;
        end else begin
            if (fifo_pop) begin
                rx_buffer_reg <= fifo_data_reg[fifo_rd_ptr_reg];
            end
            rx_done_reg <= rx_done_next; // see (RULE8) (RULE9)
            rx_error_reg <= rx_error_next; // see (RULE10)
            if (wr_rx_status) begin
                rx_ie_reg <= wdata_in[`IE_BIT];
            end
            // a new rise wins over the clearing status read
            if (rx_ie_reg && rx_rise) begin
                rx_req_reg <= 1'b1; // see (RULE12)
            end else if (rd_rx_status) begin
                rx_req_reg <= 1'b0; // see (RULE13)
            end
        end
    end

    // transmitter
    reg [3:0] tx_state_reg;
    reg [31:0] tx_count_reg;
    reg [3:0] tx_bit_reg;
    reg [7:0] tx_shift_reg;
    reg tx_done_reg;
    reg tx_ie_reg;
    reg tx_req_reg;
    // stop units reuse the bit counter; the second one ends the frame
    wire tx_unit_end = (tx_count_reg == UNIT_CYCLES - 1);
    wire tx_finish = (tx_state_reg == TX_STOP) && tx_unit_end && (tx_bit_reg == 4'h1);
    // writes while busy are ignored; software waits for done
    wire tx_start = wr_tx_buffer && tx_done_reg;
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            tx_state_reg <= TX_IDLE;
            tx_count_reg <= 32'h0000_0000;
            tx_bit_reg <= 4'h0;
            tx_shift_reg <= 8'h00;
            serial_tx_out <= 1'b1;
            tx_done_reg <= `TX_DONE_RESET; // see (RULE7)
            tx_ie_reg <= `TX_IE_RESET; // see (RULE6)
            tx_req_reg <= 1'b0;
        end else begin
            if (wr_tx_status) begin
                tx_ie_reg <= wdata_in[`IE_BIT];
            end
            if (tx_ie_reg && tx_finish) begin
                tx_req_reg <= 1'b1; // see (RULE16)
            end else if (rd_tx_status) begin
                tx_req_reg <= 1'b0; // see (RULE17)
            end
            if (tx_start) begin
                tx_done_reg <= 1'b0; // see (RULE14)
            end else if (tx_finish) begin
                tx_done_reg <= 1'b1; // see (RULE15)
            end
            if (tx_state_reg != TX_IDLE) begin
                tx_count_reg <= tx_unit_end ? 32'h0000_0000 : tx_count_reg + 32'h0000_0001;
            end
            case (tx_state_reg)
                TX_IDLE: begin
                    serial_tx_out <= 1'b1;
                    if (tx_start) begin
                        tx_shift_reg <= wdata_in; // see (RULE3)
                        tx_count_reg <= 32'h0000_0000;
                        serial_tx_out <= 1'b0; // see (RULE20)
                        tx_state_reg <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_unit_end) begin
                        serial_tx_out <= tx_shift_reg[0];
                        tx_bit_reg <= 4'h0;
                        tx_state_reg <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_unit_end) begin
                        if (tx_bit_reg == 4'h7) begin
                            serial_tx_out <= 1'b1;
                            tx_bit_reg <= 4'h0;
                            tx_state_reg <= TX_STOP;
                        end else begin
                            serial_tx_out <= tx_shift_reg[1];
                            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                            tx_bit_reg <= tx_bit_reg + 4'h1;
                        end
                    end
                end
                TX_STOP: begin
                    // two stop units close the 11-unit frame
                    if (tx_unit_end) begin
                        if (tx_bit_reg == 4'h1) begin
                            tx_state_reg <= TX_IDLE; // see (RULE18)
                        end else begin
                            tx_bit_reg <= tx_bit_reg + 4'h1;
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // read data and outputs; paths share nothing but the bus (see (RULE19))
    // unmapped and write-only addresses read back as zero
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
            rx_irq_out <= 1'b0;
            tx_irq_out <= 1'b0;
            rx_vector_out <= `RX_VECTOR_ADDR;
            tx_vector_out <= `TX_VECTOR_ADDR;
        end else begin
            rx_irq_out <= rx_req_reg;
            tx_irq_out <= tx_req_reg;
            rx_vector_out <= `RX_VECTOR_ADDR; // see (RULE1)
            tx_vector_out <= `TX_VECTOR_ADDR;
            if (rd_rx_status) begin
                rdata_out <= status_byte(rx_done_reg, rx_ie_reg, rx_error_reg); // see (RULE21)
            end else if (rd_rx_buffer) begin
                rdata_out <= rx_buffer_reg; // see (RULE2)
            end else if (rd_tx_status) begin
                rdata_out <= status_byte(tx_done_reg, tx_ie_reg, 1'b0);
            end else begin
                rdata_out <= 8'h00;
            end
        end
    end
endmodule

// ===== inc/teleprinter_regs.vh
// register map, field positions and timing for the teleprinter serial interface
`ifndef TELEPRINTER_REGS_VH
`define TELEPRINTER_REGS_VH
`define RX_STATUS_ADDR 16'hfff0
`define RX_BUFFER_ADDR 16'hfff2
`define TX_STATUS_ADDR 16'hfff4
`define TX_BUFFER_ADDR 16'hfff6
`define DONE_BIT 7
`define IE_BIT 6
`define ERROR_BIT 5
`define TX_VECTOR_ADDR 16'h00f4
`define RX_VECTOR_ADDR 16'h00f8
`define RX_IE_RESET 1'b0
`define TX_IE_RESET 1'b0
`define TX_DONE_RESET 1'b1
`define FRAME_UNITS 11
`define CHARS_PER_SEC 10
`define CLK_HZ 50000000
`define UNIT_CYCLES (`CLK_HZ / (`CHARS_PER_SEC * `FRAME_UNITS))
`endif

// ===== sim/teleprinter_checker_assertions.sv
// port checker for the teleprinter serial interface
`timescale 1ns/1ns
module teleprinter_checker #(
    parameter UNIT_CYCLES = 16
) (
    input wire core_clk_in,
    input wire reset_in,
    input wire [15:0] addr_in,
    input wire rd_in,
    input wire wr_in,
    input wire [7:0] wdata_in,
    input wire [7:0] rdata_out,
    input wire serial_tx_out,
    input wire tx_irq_out,
    input wire [15:0] rx_vector_out,
    input wire [15:0] tx_vector_out
);
    localparam U = UNIT_CYCLES;
    reg [31:0] pos_reg;
    reg [9:0] frame_reg;
    reg rx_ie_reg;
    reg tx_ie_reg;
    // pos stops a unit short of done so a write right after done always restarts it
    wire go = wr_in && addr_in == 16'hfff6 && pos_reg == 0;
    always @(posedge core_clk_in) begin
        if (reset_in) begin
            pos_reg <= 0;
            rx_ie_reg <= 1'b0;
            tx_ie_reg <= 1'b0;
        end else begin
            pos_reg <= go ? 1 : (pos_reg == 0 || pos_reg == 10 * U) ? 0 : pos_reg + 1;
            if (go) frame_reg <= {1'b1, wdata_in, 1'b0};
            if (wr_in && addr_in == 16'hfff0) rx_ie_reg <= wdata_in[6];
            if (wr_in && addr_in == 16'hfff4) tx_ie_reg <= wdata_in[6];
        end
    end
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);
    property p_vectors;
        rx_vector_out == 16'h00f8 && tx_vector_out == 16'h00f4;
    endproperty
    a_vectors: assert property (p_vectors) else $error("bad vectors");
    property p_rdata_idle;
        !rd_in |=> rdata_out == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_rx_status;
        rd_in && addr_in == 16'hfff0 |=> rdata_out[4:0] == 5'h00 && rdata_out[6] == rx_ie_reg;
    endproperty
    a_rx_status: assert property (p_rx_status) else $error("bad rx status");
    property p_tx_status;
        rd_in && addr_in == 16'hfff4 |=> rdata_out[5:0] == 6'h00 && rdata_out[6] == tx_ie_reg;
    endproperty
    a_tx_status: assert property (p_tx_status) else $error("bad tx status");
    property p_tx_busy;
        rd_in && addr_in == 16'hfff4 && pos_reg > 2 && pos_reg < 9 * U |=> !rdata_out[7];
    endproperty
    a_tx_busy: assert property (p_tx_busy) else $error("done while sending");
    property p_frame;
        pos_reg % U == U / 2 && pos_reg < 10 * U |-> serial_tx_out == frame_reg[pos_reg / U];
    endproperty
    a_frame: assert property (p_frame) else $error("bad frame unit");
    property p_idle_mark;
        pos_reg == 0 |-> serial_tx_out;
    endproperty
    a_idle_mark: assert property (p_idle_mark) else $error("idle line not mark");
    property p_no_early_irq;
        pos_reg > 2 && pos_reg < 9 * U |-> !$rose(tx_irq_out);
    endproperty
    a_no_early_irq: assert property (p_no_early_irq) else $error("early tx request");
endmodule
bind teleprinter_serial_interface teleprinter_checker #(.UNIT_CYCLES(UNIT_CYCLES)) u_check (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .addr_in(addr_in), .rd_in(rd_in),
    .wr_in(wr_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .serial_tx_out(serial_tx_out),
    .tx_irq_out(tx_irq_out), .rx_vector_out(rx_vector_out), .tx_vector_out(tx_vector_out));

// ===== sim/teleprinter_model.sv
// teleprinter model: keyboard sender and printer decoder
`timescale 1ns/1ns
module teleprinter_model #(
    parameter UNIT_CYCLES = 16
) (
    input wire clk_in,
    input wire line_in,
    output reg line_out,
    output reg [7:0] char_out,
    output reg char_valid_out
);
    reg [7:0] shift_reg;
    reg [10:0] frame_reg;
    integer i;
    integer k;
    initial begin
        line_out = 1'b1;
        char_out = 8'h00;
        char_valid_out = 1'b0;
    end
    // a low shorter than a unit stands for line noise
    task send(input [7:0] data, input integer low_cycles);
        if (low_cycles < UNIT_CYCLES) begin
            @(posedge clk_in);
            line_out <= 1'b0;
            repeat (low_cycles) @(posedge clk_in);
            line_out <= 1'b1;
        end else begin
            frame_reg = {2'b11, data, 1'b0};
            for (k = 0; k < 11; k = k + 1) begin
                @(posedge clk_in);
                line_out <= frame_reg[k];
                repeat (UNIT_CYCLES - 1) @(posedge clk_in);
            end
        end
    endtask
    always begin
        @(negedge line_in);
        repeat (UNIT_CYCLES / 2) @(posedge clk_in);
        if (line_in === 1'b0) begin
            for (i = 0; i < 8; i = i + 1) begin
                repeat (UNIT_CYCLES) @(posedge clk_in);
                shift_reg[i] = line_in;
            end
            repeat (UNIT_CYCLES) @(posedge clk_in);
            if (line_in === 1'b1) begin
                char_out <= shift_reg;
                char_valid_out <= 1'b1;
                @(posedge clk_in);
                char_valid_out <= 1'b0;
            end
        end
    end
endmodule

// ===== sim/teleprinter_serial_interface_test.sv
// self-checking bench for the teleprinter serial interface
`timescale 1ns/1ns
module teleprinter_serial_interface_test;
    localparam U = 16;
    reg core_clk_in = 1'b0;
    reg reset_in = 1'b1;
    reg [15:0] addr_in = 16'h0000;
    reg rd_in = 1'b0;
    reg wr_in = 1'b0;
    reg [7:0] wdata_in = 8'h00;
    reg rd_d = 1'b0;
    wire [7:0] rdata_out, got;
    wire serial_rx_in, serial_tx_out, rx_irq_out, tx_irq_out, got_valid;
    integer seed = 17595;
    integer n_fail = 0;
    integer tests_run = 0;
    integer i;
    reg [7:0] rd_q[$];
    reg [7:0] tx_q[$];
    reg [7:0] b, r;
    always #10 core_clk_in = ~core_clk_in;
    teleprinter_serial_interface #(.UNIT_CYCLES(U)) DUT (.core_clk_in(core_clk_in),
        .reset_in(reset_in), .addr_in(addr_in), .rd_in(rd_in), .wr_in(wr_in),
        .wdata_in(wdata_in), .rdata_out(rdata_out), .serial_rx_in(serial_rx_in),
        .serial_tx_out(serial_tx_out), .rx_irq_out(rx_irq_out), .tx_irq_out(tx_irq_out),
        .rx_vector_out(), .tx_vector_out());
    teleprinter_model #(.UNIT_CYCLES(U)) printer (.clk_in(core_clk_in), .line_in(serial_tx_out),
        .line_out(serial_rx_in), .char_out(got), .char_valid_out(got_valid));
    task check(input string what, input [7:0] exp, input [7:0] seen);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // reads note their expected byte; the watcher below pops it two cycles later
    task bus(input w, input [15:0] a, input [7:0] d);
        @(posedge core_clk_in);
        addr_in <= a;
        wdata_in <= d;
        rd_in <= !w;
        wr_in <= w;
        if (!w) rd_q.push_back(d);
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        wr_in <= 1'b0;
    endtask
    task wait_irq(input tx);
        integer n;
        n = 0;
        while ((tx ? tx_irq_out : rx_irq_out) !== 1'b1 && n < 15 * U) begin
            @(posedge core_clk_in);
            n = n + 1;
        end
        check("request in time", 8'h01, {7'h00, (tx ? tx_irq_out : rx_irq_out)});
    endtask
    task irq(input [1:0] exp);
        repeat (2) @(posedge core_clk_in);
        check("tx and rx requests", {6'h00, exp}, {6'h00, tx_irq_out, rx_irq_out});
    endtask
    always @(posedge core_clk_in) begin
        rd_d <= rd_in;
        if (rd_d) check("read data", rd_q.pop_front(), rdata_out);
    end
    always @(posedge got_valid) begin
        check("printed count", 8'h01, {7'h00, tx_q.size() != 0});
        check("printed char", tx_q.pop_front(), got);
    end
    task summarize;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_fail = n_fail + 1;
        $display("watchdog expired");
        summarize;
    end
    initial begin
        repeat (20) @(posedge core_clk_in);
        reset_in <= 1'b0;
        bus(0, 16'hfff0, 8'h00);
        bus(0, 16'hfff4, 8'h80);
        bus(0, 16'hfff8, 8'h00);
        bus(1, 16'hfff0, 8'hff);
        bus(1, 16'hfff4, 8'hff);
        bus(0, 16'hfff0, 8'h40);
        bus(0, 16'hfff4, 8'hc0);
        irq(2'b00);
        $display("test registers done");
        b = 8'($random(seed));
        r = 8'($random(seed));
        fork
            printer.send(r, U);
            begin
                tx_q.push_back(b);
                bus(1, 16'hfff6, b);
                bus(0, 16'hfff4, 8'h40);
                bus(1, 16'hfff6, ~b);
                wait_irq(1);
            end
        join
        irq(2'b11);
        bus(0, 16'hfff4, 8'hc0);
        bus(0, 16'hfff0, 8'hc0);
        irq(2'b00);
        bus(0, 16'hfff2, r);
        bus(0, 16'hfff0, 8'h40);
        $display("test duplex done");
        r = 8'($random(seed));
        printer.send(b, U);
        printer.send(r, U);
        irq(2'b01);
        bus(0, 16'hfff0, 8'he0);
        bus(0, 16'hfff2, r);
        bus(0, 16'hfff0, 8'h40);
        $display("test overrun done");
        printer.send(8'h00, U / 4);
        repeat (12 * U) @(posedge core_clk_in);
        bus(0, 16'hfff0, 8'h40);
        irq(2'b00);
        $display("test noise done");
        for (i = 0; i < 3; i = i + 1) begin
            b = 8'($random(seed));
            tx_q.push_back(b);
            bus(1, 16'hfff6, b);
            wait_irq(1);
            bus(0, 16'hfff4, 8'hc0);
        end
        repeat (2 * U) @(posedge core_clk_in);
        check("printed backlog", 8'h00, 8'(tx_q.size()));
        $display("test back to back done");
        summarize;
    end
endmodule
